// *** logic/cls_sequencer.v ***
`include "cls_defs.vh"
`timescale 1ns/100ps
`default_nettype none

// Contract
// - In auto mode with control valid and air supply normal, pressure above the unload threshold starts unloading.
// - Unloading with hibernation enabled leads to a hibernation stage with the drive stopped.
// - Unloading with hibernation disabled keeps the motor at the idle run frequency.
// - Pressure below the load threshold returns the sequencer to loading.
// - In loading the speed reference follows the pressure PID output, and only there.
// - The start stage after standby lasts the start phase time, overlapping the first acceleration ramp.
// - The unload stage lasts the unload phase time plus the ramp share inside it.
// - Leaving hibernation runs a wake-up start lasting the start phase time.
// - A stop request runs a stop stage lasting the stop phase time plus ramp share.
// - After a stop, a restart delay holds for the restart hold time before a new start.
// - Stop style defaults to ramped deceleration and applies on a normal stop only; unloading with hibernation enabled always ramps.
// - A fault or emergency stop removes drive output and lets the motor coast.

module cls_sequencer
#(
   parameter FW       = 16,
   parameter PW       = 16,
   parameter TW       = 16,
   parameter TICK_DIV = `CLS_TICK_CYCLES
)
(
   input  wire          clk_sys,
   input  wire          rst,
   input  wire          auto_mode,
   input  wire          ctrl_valid,
   input  wire          air_supply_ok,
   input  wire          hibernate_en,
   input  wire          run_cmd,
   input  wire          stop_cmd,
   input  wire          estop_cmd,
   input  wire          fault_in,
   input  wire          stop_style_select,
   input  wire [3:0]    speed_ref_source_select,
   input  wire [3:0]    pid_ref_source_select,
   input  wire [3:0]    pid_feedback_source_select,
   input  wire [PW-1:0] exhaust_pressure,
   input  wire [PW-1:0] unloading_pressure_threshold,
   input  wire [PW-1:0] loading_pressure_threshold,
   input  wire [FW-1:0] pid_freq,
   input  wire [FW-1:0] frequency_upper_limit,
   input  wire [FW-1:0] loaded_frequency_floor,
   input  wire [FW-1:0] idle_run_frequency,
   input  wire [FW-1:0] stop_frequency,
   input  wire [FW-1:0] motor_freq,
   input  wire [TW-1:0] start_phase_time,
   input  wire [TW-1:0] unload_phase_time,
   input  wire [TW-1:0] stop_phase_time,
   input  wire [TW-1:0] restart_hold_time,
   output reg  [FW-1:0] freq_ref_q,
   output reg           drive_run_q,
   output reg           ramp_stop_q,
   output reg           coast_q,
   output reg           pid_active_q,
   output reg           cfg_ok_q,
   output reg  [2:0]    stage_q
);

   localparam ST_STANDBY   = `CLS_ST_STANDBY;
   localparam ST_START     = `CLS_ST_START;
   localparam ST_LOAD      = `CLS_ST_LOAD;
   localparam ST_UNLOAD    = `CLS_ST_UNLOAD;
   localparam ST_HIBERNATE = `CLS_ST_HIBERNATE;
   localparam ST_IDLE      = `CLS_ST_IDLE;
   localparam ST_STOP      = `CLS_ST_STOP;
   localparam ST_RESTART   = `CLS_ST_RESTART;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   reg  [8:0]    raw_s1_q;
   reg  [8:0]    raw_s2_q;
   reg  [PW-1:0] pres_s1_q;
   reg  [PW-1:0] pres_s2_q;
   reg  [FW-1:0] mfreq_s1_q;
   reg  [FW-1:0] mfreq_s2_q;
   wire          tick;

   // Pins come from the panel and sensor side, so two flops each.
   // Multi-bit values are assumed slowly changing sensor readings.
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         raw_s1_q   <= 9'h000;
         raw_s2_q   <= 9'h000;
         pres_s1_q  <= {PW{1'b0}};
         pres_s2_q  <= {PW{1'b0}};
         mfreq_s1_q <= {FW{1'b0}};
         mfreq_s2_q <= {FW{1'b0}};
      end
      else
      begin
         raw_s1_q   <= {stop_style_select, fault_in, estop_cmd, stop_cmd,
                        run_cmd, hibernate_en, air_supply_ok, ctrl_valid, auto_mode};
         raw_s2_q   <= raw_s1_q;
         pres_s1_q  <= exhaust_pressure;
         pres_s2_q  <= pres_s1_q;
         mfreq_s1_q <= motor_freq;
         mfreq_s2_q <= mfreq_s1_q;
      end
   end

   wire auto_ok   = raw_s2_q[0] & raw_s2_q[1];
   wire air_ok    = raw_s2_q[2];
   wire hib_en    = raw_s2_q[3];
   wire run_s     = raw_s2_q[4];
   wire stop_s    = raw_s2_q[5];
   wire estop_s   = raw_s2_q[6];
   wire fault_s   = raw_s2_q[7];
   wire coast_sel = raw_s2_q[8];

   cls_tick_gen #(.DIV (TICK_DIV)) u_tick (.clk_sys (clk_sys), .rst (rst), .tick_q (tick));

   // ****************************************************************
   // Stage sequencer
   // ****************************************************************
   reg [2:0]    stage_d;
   reg [TW-1:0] tmr_q;
   reg          tmr_load;
   reg [TW-1:0] tmr_val;
   reg          coast_hold_q;

   wire tmr_done     = (tmr_q == {TW{1'b0}});
   wire above_unload = (pres_s2_q > unloading_pressure_threshold);
   wire below_load   = (pres_s2_q < loading_pressure_threshold);
   wire at_stop_freq = (mfreq_s2_q <= stop_frequency);
   wire abort        = fault_s | estop_s;
   // Coast latch as the outputs must see it in the very cycle of the stage that sets it.
   wire coast_hold_d = (stage_d == ST_STANDBY || stage_d == ST_START) ? 1'b0
                       : (tmr_load && stage_d == ST_RESTART && abort) ? 1'b1
                       : (tmr_load && stage_d == ST_STOP) ? coast_sel : coast_hold_q;

   // Next stage; abort has priority and runs into the restart hold.
   always @*
   begin
      stage_d  = stage_q;
      tmr_load = 1'b0;
      tmr_val  = {TW{1'b0}};
      if (abort && stage_q != ST_STANDBY && stage_q != ST_RESTART)
      begin
         stage_d  = ST_RESTART;
         tmr_load = 1'b1;
         tmr_val  = restart_hold_time;
      end
      else if (stop_s && (stage_q == ST_START || stage_q == ST_LOAD || stage_q == ST_UNLOAD
                          || stage_q == ST_IDLE || stage_q == ST_HIBERNATE))
      begin
         stage_d  = ST_STOP;
         tmr_load = 1'b1;
         tmr_val  = stop_phase_time;
      end
      else
      begin
         case (stage_q)
            ST_STANDBY:
               if (run_s && !abort)
               begin
                  stage_d  = ST_START;
                  tmr_load = 1'b1;
                  tmr_val  = start_phase_time;
               end
            ST_START:
               if (tmr_done)
                  stage_d = ST_LOAD;
            ST_LOAD:
               if (auto_ok && air_ok && above_unload)
               begin
                  stage_d  = ST_UNLOAD;
                  tmr_load = 1'b1;
                  tmr_val  = unload_phase_time;
               end
            ST_UNLOAD:
               if (below_load)
                  stage_d = ST_LOAD;
               else if (tmr_done && (!hib_en || at_stop_freq))
                  stage_d = hib_en ? ST_HIBERNATE : ST_IDLE;
            ST_HIBERNATE:
               if (below_load)
               begin
                  stage_d  = ST_START;
                  tmr_load = 1'b1;
                  tmr_val  = start_phase_time;
               end
            ST_IDLE:
               if (below_load)
                  stage_d = ST_LOAD;
            ST_STOP:
               if (tmr_done && (coast_hold_q || at_stop_freq))
               begin
                  stage_d  = ST_RESTART;
                  tmr_load = 1'b1;
                  tmr_val  = restart_hold_time;
               end
            ST_RESTART:
               if (tmr_done)
                  stage_d = ST_STANDBY;
            default:
               stage_d = ST_STANDBY;
         endcase
      end
   end

   // Timers decrement on the slow tick so long phases fit in TW bits.
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         stage_q      <= ST_STANDBY;
         tmr_q        <= {TW{1'b0}};
         coast_hold_q <= 1'b0;
      end
      else
      begin
         stage_q <= stage_d;
         if (tmr_load)
            tmr_q <= tmr_val;
         else if (tick && !tmr_done)
            tmr_q <= tmr_q - {{(TW-1){1'b0}}, 1'b1};
         coast_hold_q <= coast_hold_d;
      end
   end

   // ****************************************************************
   // Drive outputs
   // ****************************************************************
   // Clamp PID output between the loaded floor and the upper limit.
   wire [FW-1:0] clamped = (pid_freq > frequency_upper_limit) ? frequency_upper_limit
                           : (pid_freq < loaded_frequency_floor) ? loaded_frequency_floor : pid_freq;

   // Registered outputs follow the next stage so they align with stage_q.
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         freq_ref_q   <= {FW{1'b0}};
         drive_run_q  <= 1'b0;
         ramp_stop_q  <= 1'b0;
         coast_q      <= 1'b0;
         pid_active_q <= 1'b0;
         cfg_ok_q     <= 1'b0;
      end
      else
      begin
         // Advisory only; the sequencer still runs with other settings.
         cfg_ok_q     <= (speed_ref_source_select == `CLS_SPD_SRC_PID)
                         && (pid_ref_source_select == `CLS_PID_REF_SRC)
                         && (pid_feedback_source_select == `CLS_PID_FB_SRC);
         pid_active_q <= (stage_d == ST_LOAD);
         // Every stage starts from a running, unramped drive and overrides what differs.
         drive_run_q  <= 1'b1;
         ramp_stop_q  <= 1'b0;
         coast_q      <= 1'b0;
         case (stage_d)
            ST_START:
               freq_ref_q <= loaded_frequency_floor;
            ST_LOAD:
               freq_ref_q <= clamped;
            ST_UNLOAD:
            begin
               // Unloading ramps only with hibernation enabled, whatever the stop style says.
               freq_ref_q  <= hib_en ? stop_frequency : idle_run_frequency;
               ramp_stop_q <= hib_en;
            end
            ST_IDLE:
               freq_ref_q <= idle_run_frequency;
            ST_STOP:
            begin
               freq_ref_q  <= coast_hold_d ? {FW{1'b0}} : stop_frequency;
               drive_run_q <= ~coast_hold_d;
               ramp_stop_q <= ~coast_hold_d;
               coast_q     <= coast_hold_d;
            end
            default:
            begin
               // Standby, hibernation and restart hold: drive off.
               freq_ref_q  <= {FW{1'b0}};
               drive_run_q <= 1'b0;
               coast_q     <= coast_hold_d;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// *** logic/cls_tick_gen.v ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Time base divider
// ****************************************************************
module cls_tick_gen
#(
   parameter DIV = 25000
)
(
   input  wire       clk_sys,
   input  wire       rst,
   output reg        tick_q
);

   reg [31:0] cnt_q;

   // One-cycle pulse every DIV clocks; all stage timers count on it.
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b0;
      end
      else if (cnt_q >= DIV - 1)
      begin
         cnt_q  <= 32'h0;
         tick_q <= 1'b1;
      end
      else
      begin
         cnt_q  <= cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// *** shared/cls_defs.vh ***
`ifndef CLS_DEFS_VH
`define CLS_DEFS_VH

// ****************************************************************
// Stage encodings
// ****************************************************************
`define CLS_ST_STANDBY   3'h0
`define CLS_ST_START     3'h1
`define CLS_ST_LOAD      3'h2
`define CLS_ST_UNLOAD    3'h3
`define CLS_ST_HIBERNATE 3'h4
`define CLS_ST_IDLE      3'h5
`define CLS_ST_STOP      3'h6
`define CLS_ST_RESTART   3'h7

// ****************************************************************
// Timing
// ****************************************************************
`define CLS_CLK_MHZ      250
`define CLS_TICK_US      100
`define CLS_TICK_CYCLES  (`CLS_CLK_MHZ * `CLS_TICK_US)

// ****************************************************************
// Configuration encodings
// ****************************************************************
`define CLS_STOP_RAMP    1'h0
`define CLS_STOP_COAST   1'h1
`define CLS_SPD_SRC_PID  4'h6
`define CLS_PID_REF_SRC  4'h7
`define CLS_PID_FB_SRC   4'hA

`endif

// *** testbench/cls_motor_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Motor and inverter speed model
// ****************************************************************
module cls_motor_model
#(
   parameter STEP = 16'h0010
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [15:0] freq_ref_q,
   input  wire logic        drive_run_q,
   input  wire logic        coast_q,
   output var  logic [15:0] motor_freq
);
   logic [15:0] target;
   // A coasting or idle motor spins down; it never snaps to zero.
   assign target = (drive_run_q && !coast_q) ? freq_ref_q : 16'h0000;
   // Slew toward the target; a small STEP gives a slow answer.
   always @(posedge clk_sys)
   begin
      if (rst) motor_freq <= 16'h0000;
      else if (motor_freq > target + STEP) motor_freq <= motor_freq - STEP;
      else if (motor_freq + STEP < target) motor_freq <= motor_freq + STEP;
      else motor_freq <= target;
   end
endmodule
`default_nettype wire

// *** testbench/cls_seq_props.sv ***
`include "cls_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Sequencer port checker
// ****************************************************************
module cls_seq_props
#(
   parameter FW = 16
)
(
   input wire logic          clk_sys,
   input wire logic          rst,
   input wire logic          estop_cmd,
   input wire logic          fault_in,
   input wire logic [3:0]    speed_ref_source_select,
   input wire logic [3:0]    pid_ref_source_select,
   input wire logic [3:0]    pid_feedback_source_select,
   input wire logic [FW-1:0] frequency_upper_limit,
   input wire logic [FW-1:0] loaded_frequency_floor,
   input wire logic [FW-1:0] idle_run_frequency,
   input wire logic [FW-1:0] freq_ref_q,
   input wire logic          drive_run_q,
   input wire logic          coast_q,
   input wire logic          pid_active_q,
   input wire logic          cfg_ok_q,
   input wire logic [2:0]    stage_q
);
   logic cfg_match;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Selector match, held three cycles to cover the register latency.
   assign cfg_match = speed_ref_source_select == 4'h6 && pid_ref_source_select == 4'h7
                      && pid_feedback_source_select == 4'hA;
   property p_pid_load; pid_active_q == (stage_q == `CLS_ST_LOAD); endproperty
   a_pid_load: assert property (p_pid_load) else $error("PID active outside loading");
   property p_clamp; stage_q == `CLS_ST_LOAD |-> freq_ref_q >= loaded_frequency_floor
      && freq_ref_q <= frequency_upper_limit; endproperty
   a_clamp: assert property (p_clamp) else $error("Loaded reference out of range");
   property p_idle; stage_q == `CLS_ST_IDLE |-> drive_run_q && freq_ref_q == idle_run_frequency; endproperty
   a_idle: assert property (p_idle) else $error("Idle stage not at idle frequency");
   property p_hib; stage_q == `CLS_ST_HIBERNATE |-> !drive_run_q; endproperty
   a_hib: assert property (p_hib) else $error("Drive running in hibernation");
   property p_unload; stage_q == `CLS_ST_UNLOAD |-> !coast_q; endproperty
   a_unload: assert property (p_unload) else $error("Unloading coasts");
   // Abort reaches the restart stage through the two-flop synchroniser.
   property p_abort; $rose(estop_cmd || fault_in) && stage_q inside {`CLS_ST_START, `CLS_ST_LOAD, `CLS_ST_IDLE}
      |-> ##[1:4] (stage_q == `CLS_ST_RESTART && coast_q && !drive_run_q); endproperty
   a_abort: assert property (p_abort) else $error("Abort did not coast");
   property p_to_unload; $changed(stage_q) && stage_q == `CLS_ST_UNLOAD |-> $past(stage_q) == `CLS_ST_LOAD; endproperty
   a_to_unload: assert property (p_to_unload) else $error("Unload not from loading");
   property p_to_start; $changed(stage_q) && stage_q == `CLS_ST_START
      |-> $past(stage_q) inside {`CLS_ST_STANDBY, `CLS_ST_HIBERNATE}; endproperty
   a_to_start: assert property (p_to_start) else $error("Start from wrong stage");
   property p_to_standby; $changed(stage_q) && stage_q == `CLS_ST_STANDBY
      |-> $past(stage_q) == `CLS_ST_RESTART; endproperty
   a_to_standby: assert property (p_to_standby) else $error("Standby without restart delay");
   property p_cfg; cfg_match [*3] |-> cfg_ok_q; endproperty
   a_cfg: assert property (p_cfg) else $error("Config flag low");
   c_hib: cover property (stage_q == `CLS_ST_HIBERNATE);
   c_idle: cover property (stage_q == `CLS_ST_IDLE);
   c_abort: cover property (stage_q == `CLS_ST_RESTART && coast_q);
endmodule
bind cls_sequencer cls_seq_props #(.FW(FW)) u_cls_seq_props (.clk_sys, .rst, .estop_cmd, .fault_in,
   .speed_ref_source_select, .pid_ref_source_select, .pid_feedback_source_select, .frequency_upper_limit,
   .loaded_frequency_floor, .idle_run_frequency, .freq_ref_q, .drive_run_q, .coast_q, .pid_active_q,
   .cfg_ok_q, .stage_q);
`default_nettype wire

// *** testbench/cls_sequencer_tb.sv ***
`include "cls_defs.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
   $display("Error at %0t: got %h want %h", $time, a, b); end end
module cls_sequencer_tb;
   logic        clk_sys = 0, rst = 1, auto_mode = 1, ctrl_valid = 1, air_supply_ok = 1, hibernate_en = 0;
   logic        run_cmd = 0, stop_cmd = 0, estop_cmd = 0, fault_in = 0, stop_style_select = 0;
   logic [3:0]  speed_ref_source_select = 4'h6, pid_ref_source_select = 4'h7, pid_feedback_source_select = 4'hA;
   logic [15:0] exhaust_pressure = 16'h0300, unloading_pressure_threshold = 16'h0800, pid_freq = 16'h0900;
   logic [15:0] loading_pressure_threshold = 16'h0400, frequency_upper_limit = 16'h0800, stop_frequency = 16'h0040;
   logic [15:0] loaded_frequency_floor = 16'h0100, idle_run_frequency = 16'h0200, start_phase_time = 16'h0003;
   logic [15:0] unload_phase_time = 16'h0003, stop_phase_time = 16'h0003, restart_hold_time = 16'h0003;
   logic [15:0] freq_ref_q, motor_freq;
   logic        drive_run_q, ramp_stop_q, coast_q, pid_active_q, cfg_ok_q;
   logic [2:0]  stage_q;
   int          bad_count = 0, comparisons = 0, n;
   cls_sequencer #(.TICK_DIV(4)) u_cls_sequencer (.clk_sys, .rst, .auto_mode, .ctrl_valid, .air_supply_ok,
      .hibernate_en, .run_cmd, .stop_cmd, .estop_cmd, .fault_in, .stop_style_select, .speed_ref_source_select,
      .pid_ref_source_select, .pid_feedback_source_select, .exhaust_pressure, .unloading_pressure_threshold,
      .loading_pressure_threshold, .pid_freq, .frequency_upper_limit, .loaded_frequency_floor,
      .idle_run_frequency, .stop_frequency, .motor_freq, .start_phase_time, .unload_phase_time,
      .stop_phase_time, .restart_hold_time, .freq_ref_q, .drive_run_q, .ramp_stop_q, .coast_q,
      .pid_active_q, .cfg_ok_q, .stage_q);
   cls_motor_model u_cls_motor_model (.clk_sys, .rst, .freq_ref_q, .drive_run_q, .coast_q, .motor_freq);
   // ****************************************************************
   // Clock, tasks and watchdog
   // ****************************************************************
   initial forever #2 clk_sys = ~clk_sys;
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Wait for a stage with a bound; n returns the cycles spent waiting.
   task automatic await(input logic [2:0] s, output int n);
      n = 0;
      while (stage_q !== s && n < 600)
      begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(stage_q, s)
   endtask
   // The whole sequence needs a few hundred cycles, so this only cuts a hang.
   initial
   begin
      #100000;
      bad_count++;
      test_done();
   end
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial
   begin
      repeat (3) @(negedge clk_sys);
      `CHK({drive_run_q, coast_q, stage_q}, 5'h00)
      rst = 0;
      repeat (4) @(negedge clk_sys);
      `CHK(cfg_ok_q, 1'b1)
      run_cmd = 1;
      await(`CLS_ST_START, n);
      run_cmd = 0;
      `CHK(freq_ref_q, loaded_frequency_floor)
      await(`CLS_ST_LOAD, n);
      `CHK(n >= 8, 1'b1)
      `CHK(pid_active_q, 1'b1)
      repeat (3) @(negedge clk_sys);
      `CHK(freq_ref_q, frequency_upper_limit)
      pid_freq = 16'h0080;
      repeat (3) @(negedge clk_sys);
      `CHK(freq_ref_q, loaded_frequency_floor)
      hibernate_en = 1;
      exhaust_pressure = 16'h0900;
      await(`CLS_ST_UNLOAD, n);
      `CHK(ramp_stop_q, 1'b1)
      await(`CLS_ST_HIBERNATE, n);
      `CHK(n >= 8, 1'b1)
      `CHK(drive_run_q, 1'b0)
      exhaust_pressure = 16'h0300;
      await(`CLS_ST_START, n);
      await(`CLS_ST_LOAD, n);
      hibernate_en = 0;
      exhaust_pressure = 16'h0900;
      await(`CLS_ST_UNLOAD, n);
      await(`CLS_ST_IDLE, n);
      `CHK(freq_ref_q, idle_run_frequency)
      exhaust_pressure = 16'h0300;
      await(`CLS_ST_LOAD, n);
      stop_cmd = 1;
      await(`CLS_ST_STOP, n);
      `CHK(ramp_stop_q, 1'b1)
      stop_cmd = 0;
      await(`CLS_ST_RESTART, n);
      `CHK(n >= 8, 1'b1)
      `CHK(motor_freq <= stop_frequency, 1'b1)
      await(`CLS_ST_STANDBY, n);
      `CHK(n >= 8, 1'b1)
      for (int i = 0; i < 2; i++)
      begin
         run_cmd = 1;
         await(`CLS_ST_LOAD, n);
         run_cmd = 0;
         {fault_in, estop_cmd} = i ? 2'b10 : 2'b01;
         await(`CLS_ST_RESTART, n);
         `CHK({coast_q, drive_run_q}, 2'b10)
         {fault_in, estop_cmd} = 2'b00;
         await(`CLS_ST_STANDBY, n);
      end
      // Hold off unloading and spoil a selector, then stop with the coast style.
      run_cmd = 1;
      await(`CLS_ST_LOAD, n);
      {run_cmd, auto_mode, speed_ref_source_select, exhaust_pressure} = {1'b0, 1'b0, 4'h5, 16'h0900};
      repeat (8) @(negedge clk_sys);
      `CHK(stage_q, `CLS_ST_LOAD)
      `CHK(cfg_ok_q, 1'b0)
      {auto_mode, speed_ref_source_select, exhaust_pressure} = {1'b1, 4'h6, 16'h0300};
      stop_style_select = 1;
      stop_cmd = 1;
      await(`CLS_ST_STOP, n);
      stop_cmd = 0;
      `CHK({coast_q, drive_run_q, ramp_stop_q}, 3'b100)
      await(`CLS_ST_STANDBY, n);
      stop_style_select = 0;
      test_done();
   end
endmodule
`default_nettype wire
